/* File: rtl/ipc_ctrl.sv */
// Interrupt priority and acknowledgment controller with its servicing sequence.
`timescale 1ns/1ps
module ipc_ctrl
  import ipc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              mc_en_i,
  input  wire logic              instr_last_i,
  input  wire logic              instr_is_ctl_i,
  input  wire logic              enable_instr_i,
  input  wire logic              disable_instr_i,
  input  wire logic              return_from_service_instr_i,
  input  wire logic              saved_status_i,
  input  wire logic [NSRC-1:0]   src_en_set_i,
  input  wire logic [NSRC-1:0]   src_en_clr_i,
  input  wire logic [NSRC-1:0]   req_sw_set_i,
  input  wire logic [NSRC-1:0]   req_sw_clr_i,
  input  wire logic              interval_timer_irq_i,
  input  wire logic              ext_edge_irq_i,
  input  wire logic              serial_done_irq_i,
  output logic                   master_irq_enable_o,
  output logic                   in_service_status_o,
  output logic [NSRC-1:0]        source_request_flag_o,
  output logic [NSRC-1:0]        source_enable_flag_o,
  output logic [NSRC-1:0]        vectored_request_o,
  output logic                   service_o,
  output logic                   service_start_o,
  output logic                   pushed_status_o,
  output logic [1:0]             ack_src_o,
  output logic [VEC_W-1:0]       vector_o
);

  // Whole controller state, registered as one word.
  typedef struct packed {
    ipc_state_t      st;
    logic [1:0]      cnt;
    logic            master_irq_enable;
    logic            ist;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] vrq;
    logic            svc;
    logic            push;
    logic            pushed;
    logic [1:0]      src;
    logic [VEC_W-1:0] vec;
  } ipc_regs_t;

  localparam logic [1:0] SVC_LAST = 2'(SVC_CYCLES - 1);

  ipc_regs_t       q;
  ipc_regs_t       d;
  logic            instr_done;
  logic            eff_ist;
  logic            ack_take;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] req_clr;

  ipc_arb_if #(.N(NSRC)) arb_if ();

  // Priority resolution over requests that are both raised and enabled.
  ipc_prio_arb #(
    .N (NSRC)
  ) u_arb (
    .a (arb_if.arb)
  );

  // Candidate set for the arbiter.
  assign arb_if.cand = q.req & q.en;

  // An instruction finishes at the end of its last machine cycle.
  assign instr_done = mc_en_i & instr_last_i;

  // A return restores the status before the decision at the same boundary.
  assign eff_ist = (instr_done && return_from_service_instr_i) ? saved_status_i : q.ist;

  // Acknowledge only at a boundary of an ordinary instruction while idle.
  // Requests raised in the last cycle are not yet in q.req here, so they
  // wait one further instruction; earlier ones are taken now.
  assign ack_take = instr_done
                  & ~instr_is_ctl_i
                  & (q.st == IPC_IDLE)
                  & q.master_irq_enable
                  & ~eff_ist
                  & arb_if.valid;

  // Raw event pulses, one bit per source in priority order.
  assign hw_set = {serial_done_irq_i, ext_edge_irq_i, interval_timer_irq_i};

  // Next-state logic for the whole controller.
  always_comb begin
    d      = q;
    d.push = 1'b0;

    // Request flags: events and software set, software or acknowledgment clear.
    req_clr = instr_done ? req_sw_clr_i : '0;
    if (ack_take) begin
      req_clr = req_clr | arb_if.grant;
    end
    // A set in the same cycle as a clear wins, so no event is lost.
    d.req = (q.req & ~req_clr) | hw_set | (instr_done ? req_sw_set_i : '0);

    // Source enables change only when their instruction completes.
    if (instr_done) begin
      d.en = (q.en & ~src_en_clr_i) | src_en_set_i;
    end

    // Master enable follows the enable and disable instructions.
    if (instr_done && enable_instr_i) begin
      d.master_irq_enable = 1'b1;
    end else if (instr_done && disable_instr_i) begin
      d.master_irq_enable = 1'b0;
    end

    // The in-service flag is written only by return and acknowledgment.
    if (instr_done && return_from_service_instr_i) begin
      d.ist = saved_status_i;
    end

    // Servicing sequence.
    unique case (q.st)
      IPC_IDLE: begin
        if (ack_take) begin
          d.st     = IPC_SVC;
          d.cnt    = 2'h0;
          d.svc    = 1'b1;
          d.push   = 1'b1;
          d.pushed = eff_ist;
          d.ist    = 1'b1;
          d.src    = arb_if.idx;
          d.vec    = ipc_vec(arb_if.idx);
        end
      end
      IPC_SVC: begin
        if (mc_en_i) begin
          if (q.cnt == SVC_LAST) begin
            d.st  = IPC_IDLE;
            d.svc = 1'b0;
            d.cnt = 2'h0;
          end else begin
            d.cnt = q.cnt + 2'h1;
          end
        end
      end
    endcase

    // Vectored request lines reflect raised and enabled sources.
    d.vrq = d.req & d.en;
  end

  // State register; reset clears flags and the status bit.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q        <= '0;
      q.st     <= IPC_IDLE;
      q.master_irq_enable    <= RST_IME;
      q.ist    <= RST_IST;
      q.req    <= RST_FLAGS;
      q.en     <= RST_FLAGS;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register; no port writes the
  // in-service flag directly.
  assign master_irq_enable_o   = q.master_irq_enable;
  assign in_service_status_o   = q.ist;
  assign source_request_flag_o = q.req;
  assign source_enable_flag_o  = q.en;
  assign vectored_request_o    = q.vrq;
  assign service_o             = q.svc;
  assign service_start_o       = q.push;
  assign pushed_status_o       = q.pushed;
  assign ack_src_o             = q.src;
  assign vector_o              = q.vec;

  // Helper: machine cycles counted while servicing is active.
  logic [2:0] chk_mc_q;

  // Counts machine-cycle enables seen during a servicing run.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chk_mc_q <= 3'h0;
    end else if (ack_take) begin
      chk_mc_q <= 3'h0;
    end else if (q.svc && mc_en_i && chk_mc_q != 3'h7) begin
      chk_mc_q <= chk_mc_q + 3'h1;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (!rstn_i);

  // Enable instruction sets the master flag at its completion.
  property p_ime_set;
    instr_done && enable_instr_i |=> master_irq_enable_o;
  endproperty
  a_ime_set: assert property (p_ime_set)
    else $error("master enable not set by enable instruction");

  // Disable instruction alone leaves the master flag clear.
  property p_ime_clr;
    instr_done && disable_instr_i && !enable_instr_i |=> !master_irq_enable_o;
  endproperty
  a_ime_clr: assert property (p_ime_clr)
    else $error("master enable not cleared by disable instruction");

  // Acknowledgment pushes the old status and sets the in-service flag.
  property p_push;
    ack_take |=> service_start_o && in_service_status_o && !pushed_status_o;
  endproperty
  a_push: assert property (p_push)
    else $error("status push or in-service set wrong on acknowledgment");

  // Return restores the saved status bit.
  property p_return_from_service_instr;
    instr_done && return_from_service_instr_i && !ack_take |=> in_service_status_o == $past(saved_status_i);
  endproperty
  a_return_from_service_instr: assert property (p_return_from_service_instr)
    else $error("in-service flag not restored on return");

  // No acknowledgment while a routine is in service.
  property p_no_nest;
    in_service_status_o && !(instr_done && return_from_service_instr_i) |-> !ack_take;
  endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("acknowledgment while in service");

  // Servicing ends after exactly three machine cycles.
  property p_svc_len;
    $fell(service_o) |-> chk_mc_q == 3'(SVC_CYCLES);
  endproperty
  a_svc_len: assert property (p_svc_len)
    else $error("servicing length is not three machine cycles");

  // Never acknowledge at the end of a control instruction.
  property p_ctl_defer;
    instr_done && instr_is_ctl_i |-> !ack_take;
  endproperty
  a_ctl_defer: assert property (p_ctl_defer)
    else $error("acknowledged after a control instruction");

  // Every acknowledgment needs the master flag.
  property p_need_ime;
    ack_take |-> master_irq_enable_o && |(source_request_flag_o & source_enable_flag_o);
  endproperty
  a_need_ime: assert property (p_need_ime)
    else $error("acknowledged without both enables");

  // A ready request at an ordinary boundary is taken at once.
  property p_take_now;
    instr_done && !instr_is_ctl_i && !service_o && master_irq_enable_o
      && !eff_ist && |(q.req & q.en) |-> ack_take;
  endproperty
  a_take_now: assert property (p_take_now)
    else $error("ready request not acknowledged at boundary");

  // The timer wins whenever it is pending and enabled.
  property p_timer_first;
    ack_take && q.req[0] && q.en[0] |=> vector_o == VEC_TIMER;
  endproperty
  a_timer_first: assert property (p_timer_first)
    else $error("timer request lost priority");

  // Acknowledged flag drops unless a fresh event or a software set raises it again.
  property p_auto_clr;
    ack_take && arb_if.grant[0] && !interval_timer_irq_i && !req_sw_set_i[0] |=> !source_request_flag_o[0];
  endproperty
  a_auto_clr: assert property (p_auto_clr)
    else $error("timer request flag not cleared by acknowledgment");

  // The in-service flag moves only on acknowledgment or return.
  property p_ist_hold;
    !ack_take && !(instr_done && return_from_service_instr_i) |=> $stable(in_service_status_o);
  endproperty
  a_ist_hold: assert property (p_ist_hold)
    else $error("in-service flag changed without acknowledgment or return");

  // The master flag moves only on enable or disable instructions.
  property p_ime_hold;
    !(instr_done && (enable_instr_i || disable_instr_i)) |=> $stable(master_irq_enable_o);
  endproperty
  a_ime_hold: assert property (p_ime_hold)
    else $error("master enable changed without control instruction");

  // Every event leaves its request flag set, even against a clear.
  property p_req_set;
    (|hw_set) |=> (source_request_flag_o & $past(hw_set)) == $past(hw_set);
  endproperty
  a_req_set: assert property (p_req_set)
    else $error("event did not set its request flag");

  // Pending flags survive unless acknowledged or cleared by software.
  property p_pending_hold;
    !ack_take && !(instr_done && (|req_sw_clr_i))
      |=> (source_request_flag_o & $past(source_request_flag_o)) == $past(source_request_flag_o);
  endproperty
  a_pending_hold: assert property (p_pending_hold)
    else $error("pending request flag lost");

  // Vectored request lines track raised and enabled sources.
  property p_vrq;
    vectored_request_o == (source_request_flag_o & source_enable_flag_o);
  endproperty
  a_vrq: assert property (p_vrq)
    else $error("vectored request lines disagree with flags");

  // No new acknowledgment while the servicing sequence runs.
  property p_no_ack_svc;
    service_o |-> !ack_take;
  endproperty
  a_no_ack_svc: assert property (p_no_ack_svc)
    else $error("acknowledgment during servicing");

  // The start strobe lasts one cycle inside a longer servicing run.
  property p_start_pulse;
    service_start_o |=> !service_start_o && service_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("servicing start strobe too long or servicing too short");

  // Servicing starts only after an instruction boundary.
  property p_start_boundary;
    service_start_o |-> $past(instr_done);
  endproperty
  a_start_boundary: assert property (p_start_boundary)
    else $error("servicing started away from an instruction boundary");

  // Without the timer, the edge input beats the serial source.
  property p_ext_second;
    ack_take && !arb_if.cand[0] && arb_if.cand[1] |=> vector_o == VEC_EXT && ack_src_o == SRC_EXT;
  endproperty
  a_ext_second: assert property (p_ext_second)
    else $error("edge input request lost priority");

  // Scenarios worth seeing in simulation.
  c_ack_ext: cover property (ack_take && arb_if.idx == SRC_EXT);
  c_ack_ser: cover property (ack_take && arb_if.idx == SRC_SER);
  c_ctl_pending: cover property (instr_done && instr_is_ctl_i && |(q.req & q.en) && q.master_irq_enable);
  c_two_pending: cover property (ack_take && arb_if.cand[0] && arb_if.cand[2]);
  c_ret_ack: cover property (ack_take && return_from_service_instr_i);

endmodule : ipc_ctrl

/* File: rtl/ipc_pkg.sv */
// Package of constants, types and helpers for the interrupt priority control block.
// Overview of operation
// - One master enable flag gates all sources; enable sets it, disable clears it.
// - Reset clears the master enable flag to 0.
// - In-service flag sits in the status word; ordinary writes cannot change it.
// - Acknowledgment pushes the status word with in-service flag, then sets flag to 1.
// - Return-from-service restores the saved status word, flag back to 0.
// - Reset clears the in-service flag to 0, normal program state.
// - Flag 0 allows acknowledgment; flag 1 blocks every request, no nesting.
// - Servicing takes 3 machine cycles before the routine starts.
// - After an enable or disable instruction, one more instruction runs first.
// - Back-to-back control instructions defer until after the last one's follower.
// - A disable instruction after the request leaves the request pending.
// - Request set in an instruction's last cycle waits one further instruction.
// - Request set earlier is serviced right after the current instruction.
// - A source needs its own enable and the master enable.
// - Requests raised while disabled stay pending until enabling allows them.
// - Simultaneous requests: higher priority first, other pending until return.
// - Priority timer, external edge, serial; vectors 0002h, 0004h, 0008h.
// - Event sets a request flag; acknowledgment clears it automatically.
// - Reset clears all request flags and source enable flags.
package ipc_pkg;

  localparam int          NSRC       = 3;
  localparam int          VEC_W      = 16;
  localparam int          SVC_CYCLES = 3;
  localparam logic [1:0]  SRC_TIMER  = 2'h0;
  localparam logic [1:0]  SRC_EXT    = 2'h1;
  localparam logic [1:0]  SRC_SER    = 2'h2;
  localparam logic [15:0] VEC_TIMER  = 16'h0002;
  localparam logic [15:0] VEC_EXT    = 16'h0004;
  localparam logic [15:0] VEC_SER    = 16'h0008;
  localparam logic        RST_IME    = 1'b0;
  localparam logic        RST_IST    = 1'b0;
  localparam logic [2:0]  RST_FLAGS  = 3'h0;

  typedef enum logic {
    IPC_IDLE = 1'b0,
    IPC_SVC  = 1'b1
  } ipc_state_t;

  // Maps a source index to its vector table entry.
  function automatic logic [15:0] ipc_vec(input logic [1:0] idx);
    unique case (idx)
      SRC_TIMER: ipc_vec = VEC_TIMER;
      SRC_EXT:   ipc_vec = VEC_EXT;
      SRC_SER:   ipc_vec = VEC_SER;
      default:   ipc_vec = 16'h0000;
    endcase
  endfunction : ipc_vec

endpackage : ipc_pkg

/* File: rtl/ipc_arb_if.sv */
// Interface joining the controller to its fixed priority arbiter.
`timescale 1ns/1ps
interface ipc_arb_if #(parameter int N = 3);
  logic [N-1:0] cand;
  logic         valid;
  logic [1:0]   idx;
  logic [N-1:0] grant;
  modport req (output cand, input valid, input idx, input grant);
  modport arb (input cand, output valid, output idx, output grant);
endinterface : ipc_arb_if

/* File: rtl/ipc_prio_arb.sv */
// Fixed priority arbiter: the lowest source index wins.
`timescale 1ns/1ps
module ipc_prio_arb
  import ipc_pkg::*;
#(
  parameter int N = NSRC
) (
  ipc_arb_if.arb a
);

  // Scan downward so the lowest pending index is the last one kept.
  always_comb begin
    a.valid = 1'b0;
    a.idx   = 2'h0;
    a.grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (a.cand[i]) begin
        a.valid = 1'b1;
        a.idx   = i[1:0];
        a.grant = '0;
        a.grant[i] = 1'b1;
      end
    end
  end

endmodule : ipc_prio_arb

/* File: sim/ipc_core_model.sv */
// Behavioural core that paces machine cycles and instruction ends for the controller.
`timescale 1ns/1ps
module ipc_core_model (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] len_i,
  input  wire logic       service_i,
  output logic            mc_en_o,
  output logic            instr_last_o
);
  logic       ph_q;
  logic [1:0] cyc_q;

  // Strobe every clock, or every second clock when slow; count cycles of the instruction.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_q  <= 1'b0;
      cyc_q <= 2'h0;
    end else begin
      ph_q <= slow_i ? ~ph_q : 1'b1;
      if (mc_en_o && !service_i) begin
        cyc_q <= instr_last_o ? 2'h0 : cyc_q + 2'h1;
      end
    end
  end

  // The core never ends an instruction while the servicing sequence runs.
  assign mc_en_o      = ph_q;
  assign instr_last_o = !service_i && (cyc_q >= len_i - 2'h1);
endmodule : ipc_core_model

/* File: sim/ipc_ctrl_tb.sv */
// Self-checking testbench of the interrupt priority controller.
`timescale 1ns/1ps
module ipc_ctrl_tb;
  import ipc_pkg::*;
  logic        clk, rstn, ctl, en, dis, ret, sav, tm, ex, se, slow, mc, last;
  logic [2:0]  eset, eclr, sset, sclr, rf, ef, vr;
  logic [1:0]  len, as;
  logic        master_irq_enable, ist, svc, ss, psh;
  logic [15:0] vec;
  int          checks;
  int          n_mismatch;

  ipc_ctrl dut (.clock_i(clk), .rstn_i(rstn), .mc_en_i(mc), .instr_last_i(last), .instr_is_ctl_i(ctl),
    .enable_instr_i(en), .disable_instr_i(dis), .return_from_service_instr_i(ret), .saved_status_i(sav),
    .src_en_set_i(eset), .src_en_clr_i(eclr), .req_sw_set_i(sset), .req_sw_clr_i(sclr),
    .interval_timer_irq_i(tm), .ext_edge_irq_i(ex), .serial_done_irq_i(se), .master_irq_enable_o(master_irq_enable),
    .in_service_status_o(ist), .source_request_flag_o(rf), .source_enable_flag_o(ef),
    .vectored_request_o(vr), .service_o(svc), .service_start_o(ss), .pushed_status_o(psh),
    .ack_src_o(as), .vector_o(vec));
  ipc_core_model core (.clock_i(clk), .rstn_i(rstn), .slow_i(slow), .len_i(len), .service_i(svc),
    .mc_en_o(mc), .instr_last_o(last));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // One-cycle event pulse on the sources, bit 0 timer, bit 1 edge, bit 2 serial.
  task automatic ev(input logic [2:0] m);
    {se, ex, tm} = m;
    @(negedge clk);
    {se, ex, tm} = 3'h0;
  endtask : ev

  // Ends one instruction of kind {ctl,en,dis,ret}, optionally with events in its last cycle;
  // v is the vector expected to be acknowledged there, 0 for none.
  task automatic instr(input logic [3:0] k, input logic [2:0] le, input logic [15:0] v);
    int         i;
    int         n;
    logic [1:0] s;
    i = 0;
    n = 0;
    s = (v == VEC_TIMER) ? 2'h0 : (v == VEC_EXT) ? 2'h1 : 2'h2;
    while (!(mc && last) && i < 40) begin
      @(negedge clk);
      i++;
    end
    {ctl, en, dis, ret} = k;
    {se, ex, tm} = le;
    @(negedge clk);
    {ctl, en, dis, ret} = 4'h0;
    {se, ex, tm} = 3'h0;
    chk("ack", {15'h0, v != 16'h0}, {15'h0, ss});
    if (v != 16'h0) begin
      chk("vector", v, vec);
      chk("source", {14'h0, s}, {14'h0, as});
      chk("status", 16'h1, {15'h0, ist});
      chk("pushed", 16'h0, {15'h0, psh});
      chk("cleared", 16'h0, {15'h0, rf[s]});
      while (svc && i < 40) begin
        n += mc;
        @(negedge clk);
        i++;
      end
      chk("service cycles", 16'h3, n[15:0]);
    end
    if (i >= 40) begin
      n_mismatch++;
      test_done();
    end
  endtask : instr

  // Pending while disabled, released by enabling after one more instruction.
  task automatic t_pending();
    ev(3'h2);
    instr(4'h0, 3'h0, 16'h0);
    chk("flags", 16'h2, {13'h0, rf});
    chk("vreq", 16'h2, {13'h0, vr});
    instr(4'hc, 3'h0, 16'h0);
    chk("ime", 16'h1, {15'h0, master_irq_enable});
    instr(4'h0, 3'h0, VEC_EXT);
    instr(4'h1, 3'h0, 16'h0);
    chk("status", 16'h0, {15'h0, ist});
  endtask : t_pending

  // Two requests at once: timer first, no nesting, serial right after return.
  task automatic t_prio();
    ev(3'h5);
    instr(4'h0, 3'h0, VEC_TIMER);
    chk("flags", 16'h4, {13'h0, rf});
    instr(4'h0, 3'h0, 16'h0);
    instr(4'h1, 3'h0, VEC_SER);
    instr(4'h1, 3'h0, 16'h0);
  endtask : t_prio

  // A disable after the request keeps it pending.
  task automatic t_disable();
    ev(3'h2);
    instr(4'ha, 3'h0, 16'h0);
    instr(4'h0, 3'h0, 16'h0);
    chk("ime", 16'h0, {15'h0, master_irq_enable});
    chk("flags", 16'h2, {13'h0, rf});
    instr(4'hc, 3'h0, 16'h0);
    instr(4'h0, 3'h0, VEC_EXT);
    instr(4'h1, 3'h0, 16'h0);
  endtask : t_disable

  // Request in the last cycle against one earlier in a three-cycle instruction.
  task automatic t_timing();
    len = 2'h3;
    instr(4'h0, 3'h2, 16'h0);
    instr(4'h0, 3'h0, VEC_EXT);
    instr(4'h1, 3'h0, 16'h0);
    ev(3'h2);
    instr(4'h0, 3'h0, VEC_EXT);
    instr(4'h1, 3'h0, 16'h0);
  endtask : t_timing

  // Back-to-back enables on a slow core defer until the following instruction.
  task automatic t_chain();
    slow = 1'b1;
    len = 2'h1;
    ev(3'h4);
    instr(4'hc, 3'h0, 16'h0);
    instr(4'hc, 3'h0, 16'h0);
    instr(4'h0, 3'h0, VEC_SER);
    instr(4'h1, 3'h0, 16'h0);
  endtask : t_chain

  // Software set and clear of flags, and a source whose own enable is cleared.
  task automatic t_soft();
    eset = 3'h0;
    eclr = 3'h2;
    sset = 3'h2;
    instr(4'h0, 3'h0, 16'h0);
    eclr = 3'h0;
    sset = 3'h0;
    chk("enables", 16'h5, {13'h0, ef});
    chk("flags", 16'h2, {13'h0, rf});
    chk("vreq", 16'h0, {13'h0, vr});
    instr(4'h0, 3'h0, 16'h0);
    sclr = 3'h2;
    instr(4'h0, 3'h0, 16'h0);
    sclr = 3'h0;
    eset = 3'h7;
    chk("flags", 16'h0, {13'h0, rf});
    instr(4'h0, 3'h0, 16'h0);
    chk("enables", 16'h7, {13'h0, ef});
  endtask : t_soft

  // Reset, reset values, then the scenarios.
  initial begin
    {ctl, en, dis, ret, sav, tm, ex, se, slow} = 9'h0;
    {eset, eclr, sset, sclr} = 12'h0;
    len = 2'h1;
    checks = 0;
    n_mismatch = 0;
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk("ime", 16'h0, {15'h0, master_irq_enable});
    chk("status", 16'h0, {15'h0, ist});
    chk("flags", 16'h0, {13'h0, rf});
    chk("enables", 16'h0, {13'h0, ef});
    eset = 3'h7;
    t_pending();
    chk("enables", 16'h7, {13'h0, ef});
    t_prio();
    t_disable();
    t_timing();
    t_chain();
    t_soft();
    test_done();
  end
endmodule : ipc_ctrl_tb
